// ---- rtl/ext_bus_map.svh ----
// Constants for the external basic bus interface.
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define AREA_WIDTH_RESET      4'h0
`define AREA_STATE_RESET      4'hF
`define AREA_WAIT_RESET       8'hFF
`define PIN_WAIT_RESET        1'b0
`define AREA_FIELD_LSB        21
`define NORMAL_SPACE_BITS     16
`define ADDR_BITS             24
`define CS_DDR_ROMDIS_RESET   4'h1
`define CS_DDR_ROMEN_RESET    4'h0
`define ROM_BASE              24'h000000
`define RAM_BASE              24'hFFB000
`define IO_BASE               24'hFFFE00
`endif

// ---- rtl/ext_bus_pkg.sv ----
// Types for the external basic bus interface.
package ext_bus_pkg;
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} xfer_size_t;
  typedef enum {ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3} bus_state_t;
endpackage : ext_bus_pkg

// ---- rtl/ext_space_decode.sv ----
// Address decoder that marks external space and selects the area.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_map.svh"
module ext_space_decode #(
  parameter int ROM_SIZE = 24'h020000,
  parameter int RAM_SIZE = 24'h004000
) (
  input  wire logic [23:0] addr,
  input  wire logic        normal_mode,
  input  wire logic        rom_enable,
  input  wire logic        internal_ram_enable,
  output logic             is_external,
  output logic [1:0]       area
);
  logic in_rom;
  logic in_ram;
  logic in_io;
  logic [23:0] eff;
  always_comb begin
    eff = normal_mode ? {8'hFF * {7'h00, addr[15]}, addr[15:0]} : addr;
    if (normal_mode && !addr[15]) begin
      eff = {8'h00, addr[15:0]};
    end
    in_rom = rom_enable && (eff < 24'(ROM_SIZE));
    in_ram = internal_ram_enable && (eff >= `RAM_BASE) && (eff < 24'(`RAM_BASE + RAM_SIZE));
    in_io  = eff >= `IO_BASE;
    is_external = !(in_rom || in_ram || in_io);
    area = normal_mode ? 2'h0 : eff[22:21];
    if (!normal_mode && eff[23]) begin
      area = 2'h3;
    end
  end
endmodule : ext_space_decode
`default_nettype wire

// ---- rtl/ext_bus_ctrl.sv ----
// Basic external bus interface: decode, alignment, strobes and waits.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_map.svh"
module ext_bus_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    manual_rstn,
  input  wire logic                    normal_mode,
  input  wire logic                    rom_enable,
  input  wire logic                    internal_ram_enable,
  input  wire logic                    cfg_we,
  input  wire logic [3:0]              area_width_in,
  input  wire logic [3:0]              area_state_in,
  input  wire logic [7:0]              area_wait_in,
  input  wire logic                    pin_wait_enable_in,
  input  wire logic                    ddr_we,
  input  wire logic [3:0]              ddr_in,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire logic [23:0]             req_addr,
  input  wire logic                    req_write,
  input  wire ext_bus_pkg::xfer_size_t req_size,
  input  wire logic [31:0]             req_wdata,
  output logic                         resp_valid,
  output logic                         resp_external,
  output logic [31:0]                  resp_rdata,
  output logic [23:0]                  ext_addr,
  output logic [15:0]                  data_out,
  output logic [1:0]                   data_oe,
  input  wire logic [15:0]             data_in,
  output logic                         read_strobe_n,
  output logic                         upper_write_strobe_n,
  output logic                         lower_write_strobe_n,
  output logic [3:0]                   area_select_n,
  output logic [3:0]                   area_select_oe,
  input  wire logic                    wait_n,
  output logic [3:0]                   area_width,
  output logic [3:0]                   area_state,
  output logic [7:0]                   area_wait,
  output logic                         pin_wait_enable
);
  import ext_bus_pkg::*;

  bus_state_t state;
  bus_state_t next_state;
  logic [3:0]  next_area_width;
  logic [3:0]  next_area_state;
  logic [7:0]  next_area_wait;
  logic        next_pin_wait_enable;
  logic [3:0]  cs_ddr;
  logic [3:0]  next_cs_ddr;
  logic [23:0] cur_addr;
  logic [23:0] next_cur_addr;
  logic        cur_write;
  logic        next_cur_write;
  logic [31:0] wbuf;
  logic [31:0] next_wbuf;
  logic [31:0] rbuf;
  logic [31:0] next_rbuf;
  logic [2:0]  left;
  logic [2:0]  next_left;
  logic [1:0]  cur_area;
  logic [1:0]  next_cur_area;
  logic [1:0]  wcnt;
  logic [1:0]  next_wcnt;
  logic        ext;
  logic [1:0]  dec_area;
  logic        is8;
  logic        is3;
  logic        unit_word;
  logic        cur_byte;
  logic        next_cur_byte;
  logic        next_resp_valid;
  logic        next_resp_ext;

  ext_space_decode u_dec (
    .addr                (req_addr),
    .normal_mode         (normal_mode),
    .rom_enable          (rom_enable),
    .internal_ram_enable (internal_ram_enable),
    .is_external         (ext),
    .area                (dec_area)
  );

  function automatic logic [2:0] units(input logic w8, input xfer_size_t s);
    case (s)
      SIZE_BYTE: units = 3'd1;
      SIZE_WORD: units = w8 ? 3'd2 : 3'd1;
      default:   units = w8 ? 3'd4 : 3'd2;
    endcase
  endfunction : units

  assign is8 = area_width[cur_area];
  assign is3 = area_state[cur_area];
  // A byte request in a 16-bit area stays on one lane, even at an even address.
  assign unit_word = !is8 && !cur_byte && (left != 3'd0);
  assign req_ready = (state == ST_IDLE) && (left == 3'd0);

  always_comb begin
    next_area_width      = area_width;
    next_area_state      = area_state;
    next_area_wait       = area_wait;
    next_pin_wait_enable = pin_wait_enable;
    next_cs_ddr          = cs_ddr;
    if (cfg_we) begin
      next_area_width      = area_width_in;
      next_area_state      = area_state_in;
      next_area_wait       = area_wait_in;
      next_pin_wait_enable = pin_wait_enable_in;
    end
    if (ddr_we) begin
      next_cs_ddr = ddr_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      area_width      <= `AREA_WIDTH_RESET;
      area_state      <= `AREA_STATE_RESET;
      area_wait       <= `AREA_WAIT_RESET;
      pin_wait_enable <= `PIN_WAIT_RESET;
      cs_ddr          <= rom_enable ? `CS_DDR_ROMEN_RESET : `CS_DDR_ROMDIS_RESET;
    end else begin
      area_width      <= next_area_width;
      area_state      <= next_area_state;
      area_wait       <= next_area_wait;
      pin_wait_enable <= next_pin_wait_enable;
      cs_ddr          <= next_cs_ddr;
    end
  end

  logic ddr_init;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ddr_init <= 1'b1;
    end else begin
      ddr_init <= 1'b0;
    end
  end

  logic [3:0] ddr_eff;
  assign ddr_eff = ddr_init ? (rom_enable ? `CS_DDR_ROMEN_RESET : `CS_DDR_ROMDIS_RESET)
                            : cs_ddr;

  always_comb begin
    next_state      = state;
    next_cur_addr   = cur_addr;
    next_cur_write  = cur_write;
    next_cur_byte   = cur_byte;
    next_wbuf       = wbuf;
    next_rbuf       = rbuf;
    next_left       = left;
    next_cur_area   = cur_area;
    next_wcnt       = wcnt;
    next_resp_valid = 1'b0;
    next_resp_ext   = resp_external;
    case (state)
      ST_IDLE: begin
        if (left != 3'd0) begin
          next_state = ST_T1;
        end else if (req_valid) begin
          next_cur_addr  = req_addr;
          next_cur_write = req_write;
          next_cur_byte  = (req_size == SIZE_BYTE);
          next_wbuf      = req_wdata;
          next_rbuf      = 32'h0000_0000;
          next_cur_area  = dec_area;
          next_resp_ext  = ext;
          if (ext) begin
            next_left  = units(area_width[dec_area], req_size);
            next_state = ST_T1;
          end else begin
            next_resp_valid = 1'b1;
          end
        end
      end
      ST_T1: begin
        next_state = ST_T2;
        next_wcnt  = area_wait[cur_area*2 +: 2];
      end
      ST_T2, ST_TW: begin
        if (!is3) begin
          next_state = ST_IDLE;
        end else if (wcnt != 2'd0) begin
          next_wcnt  = wcnt - 2'd1;
          next_state = ST_TW;
        end else if (pin_wait_enable && !wait_n) begin
          next_state = ST_TW;
        end else begin
          next_state = ST_T3;
        end
      end
      ST_T3: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if ((state == ST_T3) || ((state == ST_T2) && !is3)) begin
      if (is8) begin
        next_rbuf = {rbuf[23:0], data_in[15:8]};
        next_wbuf = {wbuf[23:0], 8'h00};
        next_cur_addr = cur_addr + 24'd1;
      end else if (unit_word) begin
        next_rbuf = {rbuf[15:0], data_in};
        next_wbuf = {wbuf[15:0], 16'h0000};
        next_cur_addr = cur_addr + 24'd2;
      end else begin
        next_rbuf = {rbuf[23:0], cur_addr[0] ? data_in[7:0] : data_in[15:8]};
      end
      next_left = left - 3'd1;
      if (left == 3'd1) begin
        next_resp_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !manual_rstn) begin
      state         <= ST_IDLE;
      cur_addr      <= 24'h000000;
      cur_write     <= 1'b0;
      cur_byte      <= 1'b0;
      wbuf          <= 32'h0000_0000;
      rbuf          <= 32'h0000_0000;
      left          <= 3'd0;
      cur_area      <= 2'd0;
      wcnt          <= 2'd0;
      resp_valid    <= 1'b0;
      resp_external <= 1'b0;
    end else begin
      state         <= next_state;
      cur_addr      <= next_cur_addr;
      cur_write     <= next_cur_write;
      cur_byte      <= next_cur_byte;
      wbuf          <= next_wbuf;
      rbuf          <= next_rbuf;
      left          <= next_left;
      cur_area      <= next_cur_area;
      wcnt          <= next_wcnt;
      resp_valid    <= next_resp_valid;
      resp_external <= next_resp_ext;
    end
  end

  logic active;
  logic up_lane;
  logic lo_lane;
  assign active  = (state != ST_IDLE);
  assign up_lane = is8 || unit_word || !cur_addr[0];
  assign lo_lane = !is8 && (unit_word || cur_addr[0]);
  assign resp_rdata = rbuf;
  assign ext_addr   = cur_addr;

  always_comb begin
    area_select_n        = 4'hF;
    if (active) begin
      area_select_n[cur_area] = 1'b0;
    end
    area_select_oe       = ddr_eff;
    read_strobe_n        = !(active && !cur_write && state != ST_T1);
    upper_write_strobe_n = !(active && cur_write && state != ST_T1 && up_lane);
    lower_write_strobe_n = !(active && cur_write && state != ST_T1 && lo_lane);
    data_out             = is8 ? {wbuf[31:24], 8'h00}
                         : (unit_word ? wbuf[31:16] : {wbuf[31:24], wbuf[31:24]});
    data_oe              = {active && cur_write && up_lane,
                            active && cur_write && lo_lane};
  end

  AST_LWR_8BIT: assert property (@(posedge clk) disable iff (!rstn)
    (active && is8) |-> lower_write_strobe_n) else $error("lower strobe in 8-bit area");
  AST_TWO_STATE: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_T2 && !is3) |=> state == ST_IDLE) else $error("2-state extended");
  AST_NO_TW_2ST: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_TW) |-> is3) else $error("wait in 2-state area");
  AST_PROG_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_T2 && is3 && wcnt != 2'd0) |=> state == ST_TW) else $error("wait missed");
  AST_PIN_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_TW && wcnt == 2'd0 && pin_wait_enable && !wait_n) |=> state == ST_TW)
    else $error("pin wait ignored");
  AST_PIN_OFF: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_T2 && is3 && wcnt == 2'd0 && !pin_wait_enable) |=> state == ST_T3)
    else $error("pin wait while disabled");
  AST_ONE_CS: assert property (@(posedge clk) disable iff (!rstn)
    $countones(~area_select_n) <= 1) else $error("two selects low");
  AST_NORMAL_CS: assert property (@(posedge clk) disable iff (!rstn)
    normal_mode |-> area_select_n[3:1] == 3'h7) else $error("select in normal mode");
  AST_READ_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
    !cur_write |-> data_oe == 2'b00) else $error("drive during read");
  AST_CFG_RESET: assert property (@(posedge clk)
    !rstn |=> area_state == 4'hF && area_wait == 8'hFF && !pin_wait_enable)
    else $error("bad power-on config");
  AST_MANUAL_KEEP: assert property (@(posedge clk) disable iff (!rstn)
    (!manual_rstn && !cfg_we) |=> $stable(area_wait)) else $error("manual reset lost");

  COV_READ3: cover property (@(posedge clk) disable iff (!rstn) state == ST_T3 && !cur_write);
  COV_WRITE2: cover property (@(posedge clk) disable iff (!rstn)
    state == ST_T2 && !is3 && cur_write);
  COV_PINWAIT: cover property (@(posedge clk) disable iff (!rstn)
    state == ST_TW && wcnt == 2'd0 && !wait_n);
endmodule : ext_bus_ctrl
`default_nettype wire

// ---- dv/ext_mem_model.sv ----
// Behavioural external memory on the byte lanes, with an active-low wait output.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic [23:0] ext_addr,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe,
  input  wire logic        read_strobe_n,
  input  wire logic        upper_write_strobe_n,
  input  wire logic        lower_write_strobe_n,
  input  wire logic        bus8,
  input  wire logic [3:0]  stall,
  output logic [15:0]      data_in,
  output logic             wait_n
);
  logic [7:0]  mem [256];
  logic [15:0] last;
  logic [3:0]  left;
  logic [7:0]  up_a;
  logic [7:0]  lo_a;
  logic        active;
  assign up_a   = bus8 ? ext_addr[7:0] : {ext_addr[7:1], 1'b0};
  assign lo_a   = {ext_addr[7:1], 1'b1};
  assign active = !read_strobe_n || !upper_write_strobe_n || !lower_write_strobe_n;
  // The wait line is pulled up and held low for stall strobe cycles.
  assign wait_n = !(active && left != 4'h0);
  // A released data bus shows the inverse of the last value read.
  assign data_in = !read_strobe_n ? {mem[up_a], mem[lo_a]} : ~last;
  initial begin
    left = 4'h0;
    last = 16'h0;
    foreach (mem[i]) mem[i] = 8'h0;
  end
  // Only a lane that is both strobed and driven is stored.
  always @(posedge clk) begin
    if (!read_strobe_n) last <= data_in;
    if (!upper_write_strobe_n && data_oe[1]) mem[up_a] <= data_out[15:8];
    if (!lower_write_strobe_n && data_oe[0]) mem[lo_a] <= data_out[7:0];
    left <= active ? (left != 4'h0 ? left - 4'h1 : 4'h0) : stall;
  end
endmodule : ext_mem_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the external basic bus interface.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: %0h not %0h", $time, a, b); end end
module tb;
  import ext_bus_pkg::*;
  logic        clk, rstn, manual_rstn, normal_mode, rom_enable, ram_en, cfg_we, pwe_in;
  logic        ddr_we, req_valid, req_ready, req_write, resp_valid, resp_external, wait_n;
  logic        rd_n, uw_n, lw_n, pin_wait_enable, bus8, lw_seen;
  logic [3:0]  w_in, s_in, ddr_in, sel_n, sel_oe, area_width, area_state, sel_seen, stall;
  logic [7:0]  wt_in, area_wait;
  logic [23:0] req_addr, ext_addr;
  logic [31:0] req_wdata, resp_rdata;
  logic [15:0] data_out, data_in;
  logic [1:0]  data_oe, cur_area;
  xfer_size_t  req_size;
  int          num_errors, checked;
  ext_bus_ctrl dut_u (.clk(clk), .rstn(rstn), .manual_rstn(manual_rstn),
    .normal_mode(normal_mode), .rom_enable(rom_enable), .internal_ram_enable(ram_en),
    .cfg_we(cfg_we), .area_width_in(w_in), .area_state_in(s_in), .area_wait_in(wt_in),
    .pin_wait_enable_in(pwe_in), .ddr_we(ddr_we), .ddr_in(ddr_in), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_external(resp_external),
    .resp_rdata(resp_rdata), .ext_addr(ext_addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .read_strobe_n(rd_n), .upper_write_strobe_n(uw_n),
    .lower_write_strobe_n(lw_n), .area_select_n(sel_n), .area_select_oe(sel_oe),
    .wait_n(wait_n), .area_width(area_width), .area_state(area_state),
    .area_wait(area_wait), .pin_wait_enable(pin_wait_enable));
  assign cur_area = ext_addr[23] ? 2'h3 : ext_addr[22:21];
  assign bus8     = area_width[cur_area];
  ext_mem_model mem_u (.clk(clk), .ext_addr(ext_addr), .data_out(data_out),
    .data_oe(data_oe), .read_strobe_n(rd_n), .upper_write_strobe_n(uw_n),
    .lower_write_strobe_n(lw_n), .bus8(bus8), .stall(stall), .data_in(data_in),
    .wait_n(wait_n));
  always #50 clk = ~clk;
  // Driven lanes must match the write strobes.
  always @(negedge clk) if (!uw_n || !lw_n) `CHK(data_oe, {~uw_n, ~lw_n})
  task automatic complete_run();
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic cfg(input logic [3:0] w, input logic [3:0] s, input logic [7:0] wt,
                     input logic pe);
    w_in = w;
    s_in = s;
    wt_in = wt;
    pwe_in = pe;
    cfg_we = 1'b1;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask : cfg
  task automatic chk_cfg(input logic [3:0] w, input logic [3:0] s, input logic [7:0] wt,
                         input logic pe);
    `CHK({area_width, area_state, area_wait, pin_wait_enable}, {w, s, wt, pe})
  endtask : chk_cfg
  task automatic xfer(input logic [23:0] a, input logic wr, input xfer_size_t sz,
                      input logic [31:0] d, input int lat, input logic [3:0] sel);
    int          n;
    logic [31:0] m;
    n = 1;
    m = sz == SIZE_BYTE ? 32'hFF : (sz == SIZE_WORD ? 32'hFFFF : 32'hFFFFFFFF);
    sel_seen = 4'h0;
    lw_seen = 1'b0;
    `CHK(req_ready, 1'b1)
    req_valid = 1'b1;
    req_addr = a;
    req_write = wr;
    req_size = sz;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 200) begin
      sel_seen |= ~sel_n;
      lw_seen |= ~lw_n;
      n++;
      @(negedge clk);
    end
    `CHK(n, lat)
    `CHK(sel_seen, sel)
    if (!wr) `CHK(resp_rdata & m, d & m)
  endtask : xfer
  task automatic por(input logic rom);
    rom_enable = rom;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask : por
  initial begin
    {clk, manual_rstn, normal_mode, ram_en, cfg_we, pwe_in, ddr_we, req_valid} = 8'h50;
    {w_in, s_in, wt_in, ddr_in, stall, req_write, req_addr, req_wdata} = '0;
    req_size = SIZE_BYTE;
    num_errors = 0;
    checked = 0;
    @(negedge clk);
    por(1'b0);
    chk_cfg(4'h0, 4'hF, 8'hFF, 1'b0);
    `CHK(sel_oe, 4'h1)
    {ddr_in, ddr_we} = {4'hF, 1'b1};
    @(negedge clk);
    ddr_we = 1'b0;
    @(negedge clk);
    `CHK(sel_oe, 4'hF)
    cfg(4'hA, 4'h6, 8'h08, 1'b1);
    xfer(24'h200040, 1'b1, SIZE_LONG, 32'h11223344, 24, 4'h2);
    `CHK(lw_seen, 1'b0)
    xfer(24'h200040, 1'b0, SIZE_LONG, 32'h11223344, 24, 4'h2);
    xfer(24'h200041, 1'b0, SIZE_BYTE, 32'h22, 6, 4'h2);
    xfer(24'h000010, 1'b1, SIZE_LONG, 32'h01020304, 6, 4'h1);
    xfer(24'h000013, 1'b1, SIZE_BYTE, 32'h5A5A5A5A, 3, 4'h1);
    `CHK(lw_seen, 1'b1)
    xfer(24'h000010, 1'b0, SIZE_LONG, 32'h0102035A, 6, 4'h1);
    xfer(24'h000010, 1'b0, SIZE_BYTE, 32'h01, 3, 4'h1);
    xfer(24'h000012, 1'b0, SIZE_WORD, 32'h035A, 3, 4'h1);
    xfer(24'h400080, 1'b1, SIZE_WORD, 32'hBEEFBEEF, 4, 4'h4);
    stall = 4'h2;
    xfer(24'h400080, 1'b0, SIZE_WORD, 32'hBEEF, 6, 4'h4);
    stall = 4'h4;
    xfer(24'h200041, 1'b0, SIZE_BYTE, 32'h22, 8, 4'h2);
    xfer(24'h000010, 1'b0, SIZE_BYTE, 32'h01, 3, 4'h1);
    cfg(4'hA, 4'h6, 8'h08, 1'b0);
    xfer(24'h400080, 1'b0, SIZE_WORD, 32'hBEEF, 4, 4'h4);
    stall = 4'h0;
    xfer(24'hFFB000, 1'b0, SIZE_BYTE, 32'h0, 1, 4'h0);
    `CHK(resp_external, 1'b0)
    ram_en = 1'b0;
    xfer(24'hFFB000, 1'b0, SIZE_BYTE, 32'h0, 3, 4'h8);
    `CHK(resp_external, 1'b1)
    rom_enable = 1'b1;
    xfer(24'h000010, 1'b0, SIZE_BYTE, 32'h0, 1, 4'h0);
    {rom_enable, normal_mode} = 2'h1;
    xfer(24'h000010, 1'b0, SIZE_BYTE, 32'h01, 3, 4'h1);
    normal_mode = 1'b0;
    manual_rstn = 1'b0;
    repeat (2) @(negedge clk);
    manual_rstn = 1'b1;
    @(negedge clk);
    chk_cfg(4'hA, 4'h6, 8'h08, 1'b0);
    por(1'b1);
    `CHK(sel_oe, 4'h0)
    chk_cfg(4'h0, 4'hF, 8'hFF, 1'b0);
    rom_enable = 1'b0;
    xfer(24'h200040, 1'b0, SIZE_WORD, 32'h1122, 7, 4'h2);
    complete_run();
  end
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
